// >>> dac_ctrl_defs.svh
/*
 * Offsets, frame field positions, command codes, clear codes and gains for the
 * converter clear and code control block.
 * Assumes it is included by its bare name wherever these values are used.
 */
`ifndef DAC_CTRL_DEFS_SVH
`define DAC_CTRL_DEFS_SVH

// APB byte offsets
`define OFS_FRAME 12'h000
`define OFS_STATUS 12'h004
`define OFS_LEVEL0 12'h008
`define OFS_LEVEL1 12'h00c

// Serial frame layout, MSB first
`define FRAME_W 24
`define F_RW 23
`define F_SEL_HI 21
`define F_SEL_LO 19
`define F_ADR_HI 18
`define F_ADR_LO 16

// Register select codes
`define SEL_DAC 3'h0
`define SEL_RANGE 3'h1
`define SEL_POWER 3'h2
`define SEL_CTRL 3'h3

// Channel address for all channels at once
`define ADR_ALL 3'h4

// Control register commands (carried in the address field)
`define CTRL_CFG 3'h1
`define CTRL_CLEAR 3'h4
`define CTRL_LOAD 3'h5
`define CFG_CLRSEL_BIT 2

// Clear codes on the output level scale
`define CODE_ZERO 16'h0000
`define CODE_MID 16'h8000

// Status word layout
`define ST_RNG_STRIDE 4
`define ST_PWR_LSB 8
`define ST_CLRSEL_BIT 12
`define ST_CLRPIN_BIT 13

// Internal gain, scaled by 100
`define GAIN_U5 10'h0c8
`define GAIN_U10 10'h190
`define GAIN_U108 10'h1b0
`define GAIN_B5 10'h190
`define GAIN_B10 10'h320
`define GAIN_B108 10'h360

`endif

// >>> dac_ctrl_pkg.sv
/*
 * Types shared by the converter clear and code control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dac_ctrl_pkg;

    typedef enum logic [2:0] {
        RNG_U5 = 3'b000,
        RNG_U10 = 3'b001,
        RNG_U108 = 3'b010,
        RNG_B5 = 3'b011,
        RNG_B10 = 3'b100,
        RNG_B108 = 3'b101
    } range_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic [15:0] input_code;
        logic [15:0] level;
        range_t rng;
        logic pwr;
    } chan_t;

    typedef struct packed {
        chan_t [1:0] ch;
        logic clr_sel;
        logic load_outputs_n_prev;
        logic [23:0] last_frame;
        logic [31:0] rdata;
    } state_t;

    typedef struct packed {
        logic powered;
        logic bipolar;
        logic [9:0] gain_x100;
        logic [15:0] level;
    } chan_out_t;

    typedef chan_out_t [1:0] chan_outs_t;

endpackage : dac_ctrl_pkg

// >>> dac_clear_and_code_control.sv
/*
 * Control logic of a dual voltage-output converter: frame decode, power
 * gating, range and coding, output updates and the clear function.
 * Assumes an APB master on clk_sys and pins synchronous to clk_sys.
 */
// What this block does
// - Clear pin low forces all outputs to the clear code on the next clock edge.
// - One clear-select bit picks zero scale or midscale.
// - After clear release, outputs hold the cleared value until reloaded.
// - While clear pin is low, no output load is taken.
// - Software clear command forces the clear code like the clear pin; outputs then hold it until reloaded.
// - Reset zeroes all state registers, so every channel is powered down.
// - Reset range of every channel is unipolar 5 V.
// - Data writes to a powered-down channel are dropped.
// - Unipolar ranges use straight binary codes.
// - Bipolar ranges use offset binary or twos complement per pin.
// - Range selects gain 2, 4, 4.32, 4, 8 or 8.64.
// - Twos complement differs from offset binary by inverted MSB.
// - Output is proportional to level over two to the resolution.
// - Frame is 24 bits: R/W, select, address, 16 data bits.
// - Load pin low updates at frame end; high updates on its fall.
`timescale 1ns/10ps
`include "dac_ctrl_defs.svh"

module dac_clear_and_code_control #(
    parameter int NUM_CH = 2
) (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bus
    input wire dac_ctrl_pkg::apb_req_t apb_req,
    output dac_ctrl_pkg::apb_rsp_t apb_rsp,
    // Device pins
    input wire logic async_clear_n,
    input wire logic load_outputs_n,
    input wire logic bipolar_coding_select,
    // Towards the analog channels
    output dac_ctrl_pkg::chan_outs_t chan_out
);
    import dac_ctrl_pkg::*;

    // The status word and level offsets only have room for two channels
    if (NUM_CH < 1 || NUM_CH > 2) begin : g_bad_num_ch
        $error("NUM_CH must be 1 or 2");
    end

    state_t cur;
    state_t nxt;
    logic [23:0] frame;
    logic frame_go;
    logic [2:0] sel;
    logic [2:0] adr;
    logic [15:0] data;
    logic sw_clear;
    logic clr_now;
    logic load_outputs_n_fall;
    logic load_all;
    logic mapped;
    logic [1:0] hit;
    logic [1:0] single_upd;
    logic [15:0] clr_code;

    function automatic logic is_bipolar(input range_t r);
        return (r == RNG_B5) || (r == RNG_B10) || (r == RNG_B108);
    endfunction : is_bipolar

    // Level 0 is negative full scale in bipolar, zero volts in unipolar;
    // the analog string scales it by level / 65536.
    function automatic logic [15:0] to_level(input logic [15:0] c,
                                             input range_t r,
                                             input logic offs_bin);
        if (is_bipolar(r) && !offs_bin) begin
            return {~c[15], c[14:0]};
        end
        return c;
    endfunction : to_level

    function automatic logic [9:0] gain_of(input range_t r);
        case (r)
            RNG_U5: return `GAIN_U5;
            RNG_U10: return `GAIN_U10;
            RNG_U108: return `GAIN_U108;
            RNG_B5: return `GAIN_B5;
            RNG_B10: return `GAIN_B10;
            RNG_B108: return `GAIN_B108;
            default: return `GAIN_U5;
        endcase
    endfunction : gain_of

    // Frame decode; read frames are accepted but change nothing
    assign frame = apb_req.pwdata[23:0];
    assign frame_go = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == `OFS_FRAME && !frame[`F_RW];
    assign sel = frame[`F_SEL_HI:`F_SEL_LO];
    assign adr = frame[`F_ADR_HI:`F_ADR_LO];
    assign data = frame[15:0];
    assign sw_clear = frame_go && sel == `SEL_CTRL && adr == `CTRL_CLEAR;
    assign clr_now = !async_clear_n || sw_clear;
    assign clr_code = cur.clr_sel ? `CODE_MID : `CODE_ZERO;
    assign load_outputs_n_fall = cur.load_outputs_n_prev && !load_outputs_n;
    assign load_all = async_clear_n && (load_outputs_n_fall || (frame_go
        && sel == `SEL_CTRL && adr == `CTRL_LOAD));
    assign mapped = apb_req.paddr == `OFS_FRAME
        || apb_req.paddr == `OFS_STATUS
        || apb_req.paddr == `OFS_LEVEL0
        || apb_req.paddr == `OFS_LEVEL1;

    // Zero wait states: read data is latched in the setup cycle
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
    assign apb_rsp.prdata = cur.rdata;

    always_comb begin
        nxt = cur;
        hit = '0;
        single_upd = '0;
        nxt.load_outputs_n_prev = load_outputs_n;
        if (frame_go) begin
            nxt.last_frame = frame;
        end
        if (frame_go && sel == `SEL_CTRL && adr == `CTRL_CFG) begin
            nxt.clr_sel = data[`CFG_CLRSEL_BIT];
        end
        for (int i = 0; i < NUM_CH; i++) begin
            hit[i] = adr == `ADR_ALL || (!adr[0] && adr[2:1] == 2'(i));
            if (frame_go && sel == `SEL_POWER) begin
                nxt.ch[i].pwr = data[i];
            end
            if (frame_go && sel == `SEL_RANGE && hit[i]) begin
                nxt.ch[i].rng = range_t'(data[2:0]);
            end
            // Powered-down channels drop data writes
            if (frame_go && sel == `SEL_DAC && hit[i] && cur.ch[i].pwr) begin
                nxt.ch[i].input_code = data;
                single_upd[i] = !load_outputs_n && async_clear_n;
            end
            if (single_upd[i]) begin
                nxt.ch[i].level = to_level(data, cur.ch[i].rng,
                    bipolar_coding_select);
            end else if (load_all) begin
                nxt.ch[i].level = to_level(cur.ch[i].input_code,
                    cur.ch[i].rng, bipolar_coding_select);
            end
            // Clear wins over any load in the same cycle
            if (clr_now) begin
                nxt.ch[i].level = clr_code;
            end
        end
        if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            nxt.rdata = '0;
            case (apb_req.paddr)
                `OFS_FRAME: begin
                    nxt.rdata[23:0] = cur.last_frame;
                end
                `OFS_STATUS: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        nxt.rdata[`ST_RNG_STRIDE*i +: 3] = cur.ch[i].rng;
                        nxt.rdata[`ST_PWR_LSB + i] = cur.ch[i].pwr;
                    end
                    nxt.rdata[`ST_CLRSEL_BIT] = cur.clr_sel;
                    nxt.rdata[`ST_CLRPIN_BIT] = !async_clear_n;
                end
                `OFS_LEVEL0: begin
                    nxt.rdata[15:0] = cur.ch[0].level;
                end
                `OFS_LEVEL1: begin
                    nxt.rdata[15:0] = cur.ch[1].level;
                end
                default: begin
                    nxt.rdata = '0;
                end
            endcase
        end
    end

    // All zero is also range +5 V unipolar and all channels powered down
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign chan_out[g].powered = cur.ch[g].pwr;
        assign chan_out[g].bipolar = is_bipolar(cur.ch[g].rng);
        assign chan_out[g].gain_x100 = gain_of(cur.ch[g].rng);
        assign chan_out[g].level = cur.ch[g].level;
    end

    // Checks
    logic first_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
        clr_pin_a: assert property (
            !async_clear_n |=> chan_out[g].level ==
                ($past(cur.clr_sel) ? `CODE_MID : `CODE_ZERO))
            else $error("clear pin did not force clear code");
        clr_hold_a: assert property (
            async_clear_n && !single_upd[g] && !load_all && !sw_clear
                |=> $stable(chan_out[g].level))
            else $error("level moved without a load");
        clr_block_a: assert property (
            !async_clear_n [*2] |=> chan_out[g].level == `CODE_ZERO
                || chan_out[g].level == `CODE_MID)
            else $error("load taken while clear pin low");
        sw_clear_a: assert property (
            sw_clear |=> chan_out[g].level ==
                ($past(cur.clr_sel) ? `CODE_MID : `CODE_ZERO))
            else $error("software clear missed a channel");
        pd_drop_a: assert property (
            frame_go && sel == `SEL_DAC && !cur.ch[g].pwr
                |=> $stable(cur.ch[g].input_code))
            else $error("write to powered-down channel taken");
        unipolar_a: assert property (
            single_upd[g] && !is_bipolar(cur.ch[g].rng) && !sw_clear
                |=> chan_out[g].level == $past(data))
            else $error("unipolar code not straight binary");
        twos_a: assert property (
            single_upd[g] && is_bipolar(cur.ch[g].rng)
                && !bipolar_coding_select && !sw_clear
                |=> chan_out[g].level == ($past(data) ^ 16'h8000))
            else $error("twos complement MSB not inverted");
        load_outputs_n_all_a: assert property (
            load_outputs_n_fall && async_clear_n && !frame_go
                |=> chan_out[g].level == to_level($past(cur.ch[g].input_code),
                $past(cur.ch[g].rng), $past(bipolar_coding_select)))
            else $error("load pin fall did not update output");
        rst_state_a: assert property (
            first_q |-> !chan_out[g].powered && chan_out[g].level == 16'h0000)
            else $error("channel not cleared and down after reset");
        rst_range_a: assert property (
            first_q |-> cur.ch[g].rng == RNG_U5
                && chan_out[g].gain_x100 == `GAIN_U5)
            else $error("reset range is not unipolar 5 V");
    end

    clr_sel_a: assert property (
        frame_go && sel == `SEL_CTRL && adr == `CTRL_CFG
            |=> cur.clr_sel == $past(data[`CFG_CLRSEL_BIT]))
        else $error("clear select bit not stored");

    pin_clear_c: cover property (!async_clear_n ##1 async_clear_n);
    sw_clear_c: cover property (sw_clear ##1 async_clear_n);
    load_outputs_n_fall_c: cover property (frame_go ##[1:20] load_outputs_n_fall);
    single_upd_c: cover property (single_upd[1] && bipolar_coding_select);

endmodule : dac_clear_and_code_control

// >>> host_model.sv
/*
 * Host side model: APB master transfers and frame packing.
 * Assumes a slave on clk_sys; tasks are entered just after a rising edge.
 */
`timescale 1ns/10ps

module host_model (
    // System
    input wire logic clk_sys,
    // Register bus
    output dac_ctrl_pkg::apb_req_t req,
    input wire dac_ctrl_pkg::apb_rsp_t rsp
);
    import dac_ctrl_pkg::*;

    logic hung = 1'b0;

    initial req = '0;

    // Write flag clear, unused bit, select, address, data
    function automatic logic [31:0] frame(input logic [2:0] s, a,
                                          input logic [15:0] d);
        return {8'h00, 2'b00, s, a, d};
    endfunction : frame

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        n = 0;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) hung = 1'b1;
        q = rsp.prdata;
        e = rsp.pslverr;
        // Released lines carry junk so a stale request cannot pass
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        req.paddr <= ~a;
        req.pwdata <= ~d;
    endtask : xfer

endmodule : host_model

// >>> tb_top.sv
/*
 * Self-checking bench for the clear and code control block.
 * Assumes host_model drives the register bus and the bench the pins.
 */
`timescale 1ns/10ps
`include "dac_ctrl_defs.svh"

module tb_top;
    import dac_ctrl_pkg::*;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic async_clear_n = 1'b1;
    logic load_outputs_n = 1'b0;
    logic bipolar_coding_select = 1'b1;
    apb_req_t req;
    apb_rsp_t rsp;
    chan_outs_t co;
    int failures = 0;
    int total_checks = 0;
    logic [31:0] q;
    logic e;
    // Gain times 100 per range code
    logic [9:0] gains [6] = '{10'h0c8, 10'h190, 10'h1b0,
                              10'h190, 10'h320, 10'h360};

    dac_clear_and_code_control dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .apb_req(req),
        .apb_rsp(rsp),
        .async_clear_n(async_clear_n),
        .load_outputs_n(load_outputs_n),
        .bipolar_coding_select(bipolar_coding_select),
        .chan_out(co)
    );

    host_model host (
        .clk_sys(clk_sys),
        .req(req),
        .rsp(rsp)
    );

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic give_verdict;
        if (host.hung) failures++;
        if (failures == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask : chk

    task automatic xf(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        @(posedge clk_sys);
        host.xfer(w, a, d, q, e);
        if (host.hung) give_verdict();
    endtask : xf

    task automatic cmd(input logic [2:0] s, a, input logic [15:0] d);
        xf(1'b1, `OFS_FRAME, host.frame(s, a, d));
    endtask : cmd

    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle

    function automatic logic [15:0] exp_lvl(input range_t r, input logic ob,
                                            input logic [15:0] c);
        return (r >= RNG_B5 && !ob) ? {~c[15], c[14:0]} : c;
    endfunction : exp_lvl

    // A hang anywhere ends the run as a failure
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        give_verdict();
    end

    initial begin
        logic [15:0] c;
        range_t r;
        void'($urandom(32'h9611));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle();
        xf(1'b0, `OFS_STATUS, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 2; i++) begin
            chk({co[i].powered, co[i].gain_x100, co[i].level},
                {1'b0, 10'h0c8, 16'h0});
        end
        cmd(`SEL_DAC, 3'h0, 16'h1234);
        settle();
        chk(co[0].level, 16'h0);
        for (int k = 5; k >= 0; k--) begin
            cmd(`SEL_RANGE, `ADR_ALL, 16'(k));
            settle();
            chk({co[1].bipolar, co[1].gain_x100}, {1'(k > 2), gains[k]});
        end
        // Ranges first, then power both channels
        cmd(`SEL_POWER, 3'h0, 16'h0003);
        settle();
        chk({co[0].powered, co[1].powered}, 2'b11);
        for (int n = 0; n < 24; n++) begin
            r = range_t'(n % 6);
            c = (n < 2) ? 16'hffff : 16'($urandom);
            @(posedge clk_sys);
            bipolar_coding_select <= n[1];
            cmd(`SEL_RANGE, 3'h2, 16'(r));
            cmd(`SEL_DAC, 3'h2, c);
            settle();
            chk(co[1].level, exp_lvl(r, n[1], c));
        end
        @(posedge clk_sys);
        load_outputs_n <= 1'b1;
        cmd(`SEL_RANGE, `ADR_ALL, 16'h0000);
        cmd(`SEL_DAC, 3'h0, 16'h0a5a);
        cmd(`SEL_DAC, 3'h2, 16'h5a5a);
        settle();
        chk(co[0].level, 16'h0);
        @(posedge clk_sys);
        load_outputs_n <= 1'b0;
        settle();
        chk({co[0].level, co[1].level}, 32'h0a5a5a5a);
        cmd(`SEL_CTRL, `CTRL_CFG, 16'h0004);
        @(posedge clk_sys);
        async_clear_n <= 1'b0;
        settle();
        chk({co[0].level, co[1].level}, 32'h80008000);
        cmd(`SEL_DAC, 3'h0, 16'h1111);
        settle();
        chk(co[0].level, 16'h8000);
        @(posedge clk_sys);
        async_clear_n <= 1'b1;
        settle();
        chk({co[0].level, co[1].level}, 32'h80008000);
        cmd(`SEL_DAC, 3'h0, 16'h1111);
        settle();
        chk(co[0].level, 16'h1111);
        cmd(`SEL_CTRL, `CTRL_CFG, 16'h0000);
        cmd(`SEL_CTRL, `CTRL_CLEAR, 16'h0000);
        settle();
        chk({co[0].level, co[1].level}, 32'h0);
        xf(1'b0, `OFS_FRAME, 32'h0);
        chk(q, 32'h001c0000);
        xf(1'b0, 12'h010, 32'h0);
        chk({q[30:0], e}, 32'h1);
        give_verdict();
    end

endmodule : tb_top
